/* File: hdl/lem_map.svh */
// Offsets, field positions, reset values and timing counts of the line error monitor.
// Assumes a 100 MHz master clock; every timer counts that clock.
// Overview of operation
// - Activate code over 5.1 s sets loopback
// - Established loopback survives loss of activate code
// - Deactivate code over 5.1 s drops loopback, flags
// - Clearing auto enable drops loopback at once
// - AMI: same polarity successive pulses is violation
// - HDB3/B8ZS: repeated same-polarity violation is error
// - Zero run limits per coding and standard
// - Select field picks counted error type
// - Select 00 counts pattern bit errors
// - 16-bit counter, error flag per error
// - Single rail: violation pin high one bit
// - Auto mode: one-second snapshot, restart, carry
// - Second expiry sets flag, cleared by read
// - Manual mode: trigger rising edge snapshots, carries
// - Counter overflow sets overflow flag
// - Insert trigger inverts second of three marks
// - Insert trigger injects one pattern bit error
// - Driver failure status, transition flag, mask
// - Transmit clock absent over 70 cycles: tristate
// - No transmit clock loss tristate in loopback or master-timed patterns
// - Pattern clock select; auto patterns use master
// - Edge select picks transmit sampling edge
// - Master clock loss tristates the driver
`ifndef LEM_MAP_SVH
`define LEM_MAP_SVH
`define LEM_CLK_MHZ        100
`define LEM_PERSIST_MS     5100
`define LEM_SECOND_MS      1000
`define LEM_PERSIST_CYC    (`LEM_PERSIST_MS * 1000 * `LEM_CLK_MHZ)
`define LEM_SECOND_CYC     (`LEM_SECOND_MS * 1000 * `LEM_CLK_MHZ)
`define LEM_TCLK_LOSS_CYC  70
`define LEM_EXZ_AMI_ANSI   7'h0F
`define LEM_EXZ_AMI_FCC    7'h50
`define LEM_EXZ_HDB3       7'h03
`define LEM_EXZ_B8ZS       7'h07
`define LEM_A_TX_CFG       8'h02
`define LEM_A_DRV_CFG      8'h03
`define LEM_A_PATT_CFG     8'h0A
`define LEM_A_LOOP_CFG     8'h0B
`define LEM_A_ERR_CTL      8'h10
`define LEM_A_MASK0        8'h11
`define LEM_A_MASK1        8'h12
`define LEM_A_STAT0        8'h14
`define LEM_A_STAT1        8'h15
`define LEM_A_FLAG0        8'h16
`define LEM_A_FLAG1        8'h17
`define LEM_A_ERROR_COUNT_BYTE0         8'h18
`define LEM_A_ERROR_COUNT_BYTE1         8'h19
`define LEM_F_ZSTD         2
`define LEM_F_CMODE        3
`define LEM_F_TRF          4
`define LEM_F_BPVINS       5
`define LEM_F_ERRINS       6
`define LEM_MASK_RST       8'hFF
`endif

/* File: hdl/lem_monitor.sv */
// Per-channel line error monitor, error counter, error insertion and
// automatic remote loopback, with a simple byte register port.
// Assumes receive and transmit bits arrive as same-clock strobes.
`timescale 1ns/1ps
`include "lem_map.svh"
`default_nettype none
module lem_monitor
   import lem_pkg::*;
#(
   parameter int PERSIST_CYC = `LEM_PERSIST_CYC,
   parameter int SECOND_CYC  = `LEM_SECOND_CYC
)
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // Receive side
   input  wire logic       rx_bit_valid,
   input  wire logic       rx_pos,
   input  wire logic       rx_neg,
   input  wire logic [1:0] line_code,
   input  wire logic       single_rail,
   input  wire logic       prbs_bit_error,
   input  wire logic       activate_code_detected,
   input  wire logic       deactivate_code_detected,
   output logic            violation_output_pin,
   // Transmit side
   input  wire logic       tx_bit_valid,
   input  wire logic       tx_mark,
   input  wire logic       internal_pattern_active,
   input  wire logic       auto_all_ones_active,
   output logic            tx_mark_out,
   output logic            tx_invert_out,
   output logic            pattern_error_inject,
   output logic            remote_loop_active_status,
   output logic            pattern_clock_master,
   output logic            tx_clock_edge_select,
   // Pins and driver control
   input  wire logic       transmit_clock,
   input  wire logic       driver_fault,
   input  wire logic       master_clock_lost,
   output logic            line_driver_hiz,
   output logic            channel_event
);
   localparam int PW = $clog2(PERSIST_CYC + 1);
   localparam int SW = $clog2(SECOND_CYC);
   localparam logic [PW-1:0] PERSIST_V = PW'(PERSIST_CYC);
   localparam logic [SW-1:0] SECOND_V  = SW'(SECOND_CYC - 1);
   localparam logic [6:0]    TLOSS_V   = 7'(`LEM_TCLK_LOSS_CYC);
   if (PERSIST_CYC < 1 || SECOND_CYC < 2)
   begin : g_chk
      $error("lem_monitor: timer counts too small");
   end
   logic [2:0] sync_a_r, sync_b_r;
   logic       tclk_d_r;
   logic [7:0] tx_cfg_r, drv_cfg_r, patt_cfg_r, loop_cfg_r, ctl_r, mask0_r, mask1_r;
   logic [7:0] ctl_d_r, flag0_r, flag1_r;
   logic [15:0] err_cnt_r, snap_r;
   logic [PW-1:0] act_cnt_r, deact_cnt_r;
   logic [SW-1:0] sec_cnt_r;
   logic [6:0] zrun_r, tclk_cnt_r;
   logic       last_pol_r, have_last_r, last_vpol_r, have_v_r;
   logic       df_r, tloss_r;
   logic [1:0] tx_hist_r;
   logic       bpv_pend_r;
   lem_loop_t  loop_r;

   // Three pins each pass two flip-flops: tclk, fault, master loss.
   always_ff @(posedge clock)
   begin
      sync_a_r <= {master_clock_lost, driver_fault, transmit_clock};
      sync_b_r <= sync_a_r;
      tclk_d_r <= sync_b_r[0];
   end
   function automatic logic [6:0] zero_limit(input logic [1:0] code, input logic fcc);
      unique case (code)
         CODE_HDB3: zero_limit = `LEM_EXZ_HDB3;
         CODE_B8ZS: zero_limit = `LEM_EXZ_B8ZS;
         default:   zero_limit = fcc ? `LEM_EXZ_AMI_FCC : `LEM_EXZ_AMI_ANSI;
      endcase
   endfunction
   wire arle      = loop_cfg_r[0];
   wire act_done  = arle && activate_code_detected && act_cnt_r == PERSIST_V;
   wire deact_done = arle && deactivate_code_detected && deact_cnt_r == PERSIST_V;
   wire rd_flag0  = reg_rd && reg_addr == `LEM_A_FLAG0;
   wire rd_flag1  = reg_rd && reg_addr == `LEM_A_FLAG1;

   // Persistence timers count master clock cycles of continuous code.
   always_ff @(posedge clock)
   begin
      if (!reset_n || loop_r != LOOP_OFF || !arle || !activate_code_detected)
         act_cnt_r <= '0;
      else if (act_cnt_r != PERSIST_V)
         act_cnt_r <= act_cnt_r + 1'b1;
      if (!reset_n || loop_r != LOOP_ON || !arle || !deactivate_code_detected)
         deact_cnt_r <= '0;
      else if (deact_cnt_r != PERSIST_V)
         deact_cnt_r <= deact_cnt_r + 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         loop_r <= LOOP_OFF;
      else
         unique case (loop_r)
            LOOP_OFF: if (act_done) loop_r <= LOOP_ON;
            LOOP_ON:
               if (!arle)
                  loop_r <= LOOP_OFF;
               else if (deact_done)
                  loop_r <= LOOP_OFF;
               // Loss of the activate code alone never drops the loop.
         endcase
   end

   // Receive error detection.
   wire rx_mark = rx_pos | rx_neg;
   wire bpv_ev  = rx_bit_valid && rx_mark && have_last_r && rx_pos == last_pol_r;
   wire is_ami  = line_code == CODE_AMI;
   wire cv_ev   = bpv_ev && (is_ami || (have_v_r && rx_pos == last_vpol_r));
   wire exz_ev  = rx_bit_valid && !rx_mark &&
                  zrun_r == zero_limit(line_code, ctl_r[`LEM_F_ZSTD]);
   logic cnt_inc;
   always_comb
   begin
      unique case (lem_sel_t'(ctl_r[1:0]))
         SEL_PRBS: cnt_inc = prbs_bit_error;
         SEL_CV:   cnt_inc = cv_ev;
         SEL_EXZ:  cnt_inc = exz_ev;
         SEL_BOTH: cnt_inc = cv_ev | exz_ev;
      endcase
   end
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         {have_last_r, last_pol_r, have_v_r, last_vpol_r, zrun_r} <= '0;
      else if (rx_bit_valid)
      begin
         if (rx_mark)
         begin
            have_last_r <= 1'b1;
            last_pol_r  <= rx_pos;
            zrun_r      <= '0;
         end
         else if (zrun_r != 7'h7F)
            zrun_r <= zrun_r + 1'b1;
         if (bpv_ev)
         begin
            have_v_r    <= 1'b1;
            last_vpol_r <= rx_pos;
         end
      end
   end
   always_ff @(posedge clock)
      violation_output_pin <= reset_n && single_rail && cv_ev;
   // Error counter with auto and manual reporting.
   wire cmode    = ctl_r[`LEM_F_CMODE];
   wire expire   = cmode && sec_cnt_r == SECOND_V;
   wire trf_rise = ctl_r[`LEM_F_TRF] && !ctl_d_r[`LEM_F_TRF];
   wire transfer = expire || (!cmode && trf_rise);
   // An error taken during a transfer opens the next round, so it cannot overflow.
   wire ovf      = cnt_inc && !transfer && err_cnt_r == 16'hFFFF;

   always_ff @(posedge clock)
   begin
      if (!reset_n || !cmode || expire)
         sec_cnt_r <= '0;
      else
         sec_cnt_r <= sec_cnt_r + 1'b1;
   end
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         {err_cnt_r, snap_r} <= '0;
      else if (transfer)
      begin
         snap_r    <= err_cnt_r;
         err_cnt_r <= {15'h0, cnt_inc};
      end
      else
         err_cnt_r <= err_cnt_r + {15'h0, cnt_inc};
   end
   // Sticky flags: a set in the cycle of a read-clear wins.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         {flag0_r, flag1_r} <= '0;
      else
      begin
         flag0_r[0] <= (flag0_r[0] && !rd_flag0) || (df_r != (sync_b_r[1] && !drv_cfg_r[0]));
         flag0_r[1] <= (flag0_r[1] && !rd_flag0) || (loop_r == LOOP_ON && deact_done);
         flag0_r[2] <= (flag0_r[2] && !rd_flag0) || (!tloss_r && tclk_cnt_r == TLOSS_V);
         flag1_r[0] <= (flag1_r[0] && !rd_flag1) || cnt_inc;
         flag1_r[1] <= (flag1_r[1] && !rd_flag1) || expire;
         flag1_r[2] <= (flag1_r[2] && !rd_flag1) || ovf;
      end
   end

   always_ff @(posedge clock)
      channel_event <= reset_n && |({flag1_r[2:0], flag0_r[2:0]} &
                                     ~{mask1_r[2:0], mask0_r[2:0]});
   // Driver failure and transmit clock loss.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         {df_r, tclk_cnt_r, tloss_r} <= '0;
      else
      begin
         df_r <= sync_b_r[1] && !drv_cfg_r[0];
         if (sync_b_r[0] != tclk_d_r)
         begin
            tclk_cnt_r <= '0;
            tloss_r    <= 1'b0;
         end
         else if (tclk_cnt_r != TLOSS_V)
            tclk_cnt_r <= tclk_cnt_r + 1'b1;
         else
            tloss_r <= 1'b1;
      end
   end

   wire master_patt = patt_cfg_r[0] || auto_all_ones_active || patt_cfg_r[1];
   wire exempt = loop_r == LOOP_ON || (internal_pattern_active && master_patt);
   always_ff @(posedge clock)
   begin
      line_driver_hiz <= !reset_n || sync_b_r[2] || (tloss_r && !exempt);
      pattern_clock_master      <= reset_n && master_patt;
      tx_clock_edge_select      <= reset_n && tx_cfg_r[0];
      remote_loop_active_status <= reset_n && loop_r == LOOP_ON;
   end
   // Transmit error insertion; data leaves one bit late for lookahead.
   wire bpv_rise = ctl_r[`LEM_F_BPVINS] && !ctl_d_r[`LEM_F_BPVINS];
   wire three    = tx_bit_valid && tx_mark && tx_hist_r == 2'b11;
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         {tx_hist_r, bpv_pend_r, tx_mark_out, tx_invert_out} <= '0;
      else
      begin
         bpv_pend_r <= (bpv_pend_r || bpv_rise) && !(bpv_pend_r && three);
         if (tx_bit_valid)
         begin
            tx_hist_r     <= {tx_hist_r[0], tx_mark};
            tx_mark_out   <= tx_hist_r[0];
            tx_invert_out <= bpv_pend_r && three;
         end
      end
   end

   always_ff @(posedge clock)
      pattern_error_inject <= reset_n && ctl_r[`LEM_F_ERRINS] && !ctl_d_r[`LEM_F_ERRINS];
   // Register file.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         {tx_cfg_r, drv_cfg_r, patt_cfg_r, loop_cfg_r, ctl_r, ctl_d_r} <= '0;
         mask0_r <= `LEM_MASK_RST;
         mask1_r <= `LEM_MASK_RST;
      end
      else
      begin
         ctl_d_r <= ctl_r;
         if (reg_wr)
            unique case (reg_addr)
               `LEM_A_TX_CFG:   tx_cfg_r   <= reg_wdata;
               `LEM_A_DRV_CFG:  drv_cfg_r  <= reg_wdata;
               `LEM_A_PATT_CFG: patt_cfg_r <= reg_wdata;
               `LEM_A_LOOP_CFG: loop_cfg_r <= reg_wdata;
               `LEM_A_ERR_CTL:  ctl_r      <= reg_wdata;
               `LEM_A_MASK0:    mask0_r    <= reg_wdata;
               `LEM_A_MASK1:    mask1_r    <= reg_wdata;
               default: ;
            endcase
      end
   end
   always_ff @(posedge clock)
   begin
      reg_rvalid <= reset_n && reg_rd;
      if (!reset_n || !reg_rd)
         reg_rdata <= '0;
      else
         unique case (reg_addr)
            `LEM_A_TX_CFG:   reg_rdata <= tx_cfg_r;
            `LEM_A_DRV_CFG:  reg_rdata <= drv_cfg_r;
            `LEM_A_PATT_CFG: reg_rdata <= patt_cfg_r;
            `LEM_A_LOOP_CFG: reg_rdata <= loop_cfg_r;
            `LEM_A_ERR_CTL:  reg_rdata <= ctl_r;
            `LEM_A_MASK0:    reg_rdata <= mask0_r;
            `LEM_A_MASK1:    reg_rdata <= mask1_r;
            `LEM_A_STAT0:    reg_rdata <= {4'h0, activate_code_detected,
                                           deactivate_code_detected, tloss_r, df_r};
            `LEM_A_STAT1:    reg_rdata <= {7'h0, loop_r == LOOP_ON};
            `LEM_A_FLAG0:    reg_rdata <= flag0_r;
            `LEM_A_FLAG1:    reg_rdata <= flag1_r;
            `LEM_A_ERROR_COUNT_BYTE0:     reg_rdata <= snap_r[7:0];
            `LEM_A_ERROR_COUNT_BYTE1:     reg_rdata <= snap_r[15:8];
            default:         reg_rdata <= '0;
         endcase
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence act_held_s;
      loop_r == LOOP_OFF && act_done;
   endsequence
   sequence deact_held_s;
      loop_r == LOOP_ON && deact_done;
   endsequence
   loop_setup_a: assert property (act_held_s |=> ##1 remote_loop_active_status)
      else $error("loopback not set up after activate code");
   loop_hold_a: assert property (loop_r == LOOP_ON && arle && !deactivate_code_detected
      |=> loop_r == LOOP_ON)
      else $error("loopback dropped without deactivate code");
   loop_tear_a: assert property (deact_held_s |=> loop_r == LOOP_OFF && flag0_r[1])
      else $error("loopback not removed by deactivate code");
   force_off_a: assert property (!arle |=> loop_r == LOOP_OFF)
      else $error("loopback kept with auto enable cleared");
   cv_pin_a: assert property (single_rail && cv_ev |=> violation_output_pin)
      else $error("violation pin not raised");
   snap_load_a: assert property (transfer |=> snap_r == $past(err_cnt_r)
      && err_cnt_r == {15'h0, $past(cnt_inc)})
      else $error("count snapshot wrong");
   sec_flag_a: assert property (cmode && sec_cnt_r == SECOND_V |=> flag1_r[1])
      else $error("second expiry flag missing");
   ovf_flag_a: assert property (ovf |=> flag1_r[2] && err_cnt_r == 16'h0000)
      else $error("overflow not flagged");
   tloss_hiz_a: assert property (tloss_r && !exempt |=> line_driver_hiz)
      else $error("driver not tristated on clock loss");
   violation_insert_trigger_a: assert property (bpv_pend_r && three |=> tx_invert_out && !bpv_pend_r)
      else $error("violation insertion missed");
endmodule
`default_nettype wire

/* File: hdl/lem_pkg.sv */
// Types shared by the line error monitor.
// Assumes nothing of its surroundings.
package lem_pkg;
   typedef enum logic [1:0] {LOOP_OFF = 2'b01, LOOP_ON = 2'b10} lem_loop_t;
   typedef enum logic [1:0] {SEL_PRBS = 2'h0, SEL_CV = 2'h1, SEL_EXZ = 2'h2,
                             SEL_BOTH = 2'h3} lem_sel_t;
   typedef enum logic [1:0] {CODE_AMI = 2'h0, CODE_HDB3 = 2'h1,
                             CODE_B8ZS = 2'h2} lem_code_t;
endpackage

/* File: tb/lem_far_end.sv */
// Far-end line equipment: sends inband loop codes and line marks on request.
// Assumes the bench asks for each bit one master clock cycle ahead.
`timescale 1ns/1ps
`default_nettype none
module lem_far_end
(
   // Clock
   input  wire logic       clock,
   // Requests from the bench
   input  wire logic [1:0] code_cmd,
   input  wire logic       bit_go,
   input  wire logic       bit_mark,
   input  wire logic       bit_pol,
   // Line toward the monitor
   output logic            rx_bit_valid,
   output logic            rx_pos,
   output logic            rx_neg,
   output logic            activate_code_detected,
   output logic            deactivate_code_detected
);
   initial
   begin
      {rx_bit_valid, rx_pos, rx_neg} = 3'h0;
      {activate_code_detected, deactivate_code_detected} = 2'h0;
   end
   // Spaces carry no mark on either rail, so a stale polarity never leaks.
   always @(posedge clock)
   begin
      activate_code_detected   <= (code_cmd == 2'h1);
      deactivate_code_detected <= (code_cmd == 2'h2);
      rx_bit_valid             <= bit_go;
      rx_pos                   <= bit_go & bit_mark & bit_pol;
      rx_neg                   <= bit_go & bit_mark & ~bit_pol;
   end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the line error monitor with short timer counts.
// Assumes the far-end model drives the receive line and the loop codes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import lem_pkg::*;
   localparam int PC = 20;
   localparam int SC = 50;
   logic clock, reset_n, reg_wr, reg_rd, reg_rvalid, rx_bit_valid, rx_pos, rx_neg;
   logic single_rail, prbs_bit_error, activate_code_detected, deactivate_code_detected;
   logic violation_output_pin, tx_bit_valid, tx_mark, internal_pattern_active;
   logic auto_all_ones_active, tx_mark_out, tx_invert_out, pattern_error_inject;
   logic remote_loop_active_status, pattern_clock_master, tx_clock_edge_select;
   logic transmit_clock, driver_fault, master_clock_lost, line_driver_hiz, channel_event;
   logic bit_go, bit_mark, bit_pol, tclk_run;
   logic [1:0] line_code, code_cmd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, ctl;
   logic [7:0] exp_q[$], msk_q[$];
   int         failures = 0, samples_checked = 0, vio_cnt = 0, inj_cnt = 0, seed, n;
   logic [1:0] zc[4] = '{CODE_AMI, CODE_AMI, CODE_HDB3, CODE_B8ZS};
   logic       zs[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   int         zl[4] = '{15, 80, 3, 7};

   lem_monitor #(.PERSIST_CYC(PC), .SECOND_CYC(SC)) u_dut
   (
      .clock, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
      .rx_bit_valid, .rx_pos, .rx_neg, .line_code, .single_rail, .prbs_bit_error,
      .activate_code_detected, .deactivate_code_detected, .violation_output_pin,
      .tx_bit_valid, .tx_mark, .internal_pattern_active, .auto_all_ones_active,
      .tx_mark_out, .tx_invert_out, .pattern_error_inject, .remote_loop_active_status,
      .pattern_clock_master, .tx_clock_edge_select, .transmit_clock, .driver_fault,
      .master_clock_lost, .line_driver_hiz, .channel_event
   );
   lem_far_end u_far
   (
      .clock, .code_cmd, .bit_go, .bit_mark, .bit_pol, .rx_bit_valid, .rx_pos, .rx_neg,
      .activate_code_detected, .deactivate_code_detected
   );

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock)
      if (tclk_run)
         transmit_clock <= #1 ~transmit_clock;

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      #900000;
      failures++;
      $display("[ERR] run expected done seen timeout");
      summarize();
   end

   task automatic chk8(input string nm, input logic [7:0] e, g, m);
      samples_checked++;
      if ((g & m) !== (e & m))
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e & m, g & m);
      end
   endtask
   task automatic chk1(input string nm, input logic e, g);
      chk8(nm, {7'h0, e}, {7'h0, g}, 8'h01);
   endtask
   // Read answers are matched against the oldest outstanding note.
   always @(posedge clock)
   begin
      if (reg_rvalid === 1'b1)
         chk8("reg_rdata", exp_q.pop_front(), reg_rdata, msk_q.pop_front());
      if (violation_output_pin === 1'b1)
         vio_cnt++;
      if (pattern_error_inject === 1'b1)
         inj_cnt++;
   end

   task automatic step(input int k = 1);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic wr(input logic [7:0] a, d);
      step();
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      step();
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e, m);
      step();
      reg_rd = 1'b1;
      reg_addr = a;
      exp_q.push_back(e);
      msk_q.push_back(m);
      step();
      reg_rd = 1'b0;
   endtask
   task automatic xfer(input logic [15:0] e, input logic [7:0] m);
      wr(8'h10, ctl | 8'h10);
      wr(8'h10, ctl);
      rd(8'h18, e[7:0], m);
      rd(8'h19, e[15:8], m);
   endtask
   task automatic rxb(input logic m, p);
      step();
      bit_go = 1'b1;
      bit_mark = m;
      bit_pol = p;
      step();
      bit_go = 1'b0;
   endtask
   task automatic txb(input logic m);
      step();
      tx_bit_valid = 1'b1;
      tx_mark = m;
      step();
      tx_bit_valid = 1'b0;
   endtask
   task automatic code(input logic [1:0] c, input int k);
      code_cmd = c;
      step(k);
      code_cmd = 2'h0;
      step(4);
   endtask

   initial
   begin
      seed = 32'ha8df616a;
      {reset_n, reg_wr, reg_rd, bit_go, bit_mark, bit_pol, tx_bit_valid, tx_mark} = '0;
      {single_rail, prbs_bit_error, internal_pattern_active, auto_all_ones_active} = '0;
      {driver_fault, master_clock_lost, transmit_clock, line_code, code_cmd} = '0;
      {reg_addr, reg_wdata, ctl} = '0;
      tclk_run = 1'b1;
      repeat (8) @(posedge clock);
      #1 reset_n = 1'b1;
      step(3);
      chk1("line_driver_hiz", 1'b0, line_driver_hiz);
      rd(8'h12, 8'hFF, 8'hFF);
      rd(8'h7F, 8'h00, 8'hFF);
      wr(8'h18, 8'hA5);
      rd(8'h18, 8'h00, 8'hFF);
      done("reset");
      wr(8'h0B, 8'h01);
      code(2'h1, 15);
      chk1("loop_status", 1'b0, remote_loop_active_status);
      code(2'h1, PC + 8);
      rd(8'h15, 8'h01, 8'h01);
      tclk_run = 1'b0;
      step(90);
      chk1("line_driver_hiz", 1'b0, line_driver_hiz);
      rd(8'h14, 8'h02, 8'h02);
      tclk_run = 1'b1;
      step(30);
      chk1("loop_status", 1'b1, remote_loop_active_status);
      code(2'h2, PC + 8);
      chk1("loop_status", 1'b0, remote_loop_active_status);
      rd(8'h16, 8'h02, 8'h02);
      code(2'h1, PC + 8);
      chk1("loop_status", 1'b1, remote_loop_active_status);
      wr(8'h0B, 8'h00);
      step(2);
      chk1("loop_status", 1'b0, remote_loop_active_status);
      done("loopback");
      tclk_run = 1'b0;
      step(60);
      chk1("line_driver_hiz", 1'b0, line_driver_hiz);
      step(20);
      chk1("line_driver_hiz", 1'b1, line_driver_hiz);
      tclk_run = 1'b1;
      step(6);
      chk1("line_driver_hiz", 1'b0, line_driver_hiz);
      rd(8'h14, 8'h00, 8'h02);
      master_clock_lost = 1'b1;
      step(4);
      chk1("line_driver_hiz", 1'b1, line_driver_hiz);
      master_clock_lost = 1'b0;
      wr(8'h02, 8'h01);
      wr(8'h0A, 8'h01);
      step(2);
      chk1("edge_select", 1'b1, tx_clock_edge_select);
      chk1("pattern_master", 1'b1, pattern_clock_master);
      internal_pattern_active = 1'b1;
      tclk_run = 1'b0;
      step(90);
      chk1("line_driver_hiz", 1'b0, line_driver_hiz);
      tclk_run = 1'b1;
      internal_pattern_active = 1'b0;
      wr(8'h0A, 8'h00);
      auto_all_ones_active = 1'b1;
      step(2);
      chk1("pattern_master", 1'b1, pattern_clock_master);
      auto_all_ones_active = 1'b0;
      done("clocks");
      wr(8'h11, 8'hFE);
      driver_fault = 1'b1;
      step(4);
      chk1("channel_event", 1'b1, channel_event);
      rd(8'h14, 8'h01, 8'h01);
      rd(8'h16, 8'h01, 8'h01);
      driver_fault = 1'b0;
      step(4);
      rd(8'h16, 8'h01, 8'h01);
      rd(8'h16, 8'h00, 8'h01);
      wr(8'h03, 8'h01);
      driver_fault = 1'b1;
      step(4);
      rd(8'h14, 8'h00, 8'h01);
      driver_fault = 1'b0;
      wr(8'h03, 8'h00);
      wr(8'h11, 8'hFF);
      done("driver");
      ctl = 8'h01;
      single_rail = 1'b1;
      wr(8'h10, ctl);
      xfer(16'h0000, 8'h00);
      vio_cnt = 0;
      rxb(1, 1);
      rxb(0, 0);
      rxb(1, 1);
      rxb(1, 0);
      step(3);
      chk8("violation_pulses", 8'h01, 8'(vio_cnt), 8'hFF);
      wr(8'h12, 8'hFE);
      step(2);
      chk1("channel_event", 1'b1, channel_event);
      rd(8'h17, 8'h01, 8'h01);
      wr(8'h12, 8'hFF);
      single_rail = 1'b0;
      rxb(1, 1);
      rxb(1, 1);
      step(3);
      chk8("violation_pulses", 8'h01, 8'(vio_cnt), 8'hFF);
      xfer(16'h0002, 8'hFF);
      line_code = CODE_HDB3;
      rxb(1, 1);
      rxb(1, 1);
      xfer(16'h0000, 8'h00);
      // Two violations of alternating polarity are substitutions; the third repeats one.
      for (int i = 0; i < 5; i++)
         rxb(1, i > 1);
      xfer(16'h0001, 8'hFF);
      done("violations");
      for (int i = 0; i < 4; i++)
      begin
         line_code = zc[i];
         ctl = {5'h0, zs[i], 2'h2};
         wr(8'h10, ctl);
         rxb(1, 1);
         xfer(16'h0000, 8'h00);
         repeat (zl[i]) rxb(0, 0);
         rxb(1, 0);
         repeat (zl[i] + 1) rxb(0, 0);
         rxb(1, 1);
         xfer(16'h0001, 8'hFF);
      end
      done("zero_runs");
      ctl = 8'h00;
      wr(8'h10, ctl);
      n = ($random(seed) & 32'h3) + 2;
      repeat (n)
      begin
         step();
         prbs_bit_error = 1'b1;
         step();
         prbs_bit_error = 1'b0;
      end
      xfer(16'(n), 8'hFF);
      ctl = 8'h08;
      wr(8'h10, ctl);
      repeat (2) rxb(0, 0);
      prbs_bit_error = 1'b1;
      step(2);
      prbs_bit_error = 1'b0;
      step(SC);
      rd(8'h18, 8'h02, 8'hFF);
      rd(8'h19, 8'h00, 8'hFF);
      rd(8'h17, 8'h02, 8'h02);
      rd(8'h17, 8'h00, 8'h02);
      ctl = 8'h00;
      wr(8'h10, ctl);
      xfer(16'h0000, 8'h00);
      prbs_bit_error = 1'b1;
      step(65539);
      prbs_bit_error = 1'b0;
      rd(8'h17, 8'h04, 8'h04);
      xfer(16'h0003, 8'hFF);
      done("counting");
      wr(8'h10, 8'h20);
      for (int i = 0; i < 7; i++)
      begin
         txb(7'h3B >> i);
         chk1("tx_invert_out", i == 5, tx_invert_out);
         if (i > 0)
            chk1("tx_mark_out", 7'h3B >> (i - 1), tx_mark_out);
      end
      inj_cnt = 0;
      wr(8'h10, 8'h60);
      wr(8'h10, 8'h60);
      step(3);
      chk8("inject_pulses", 8'h01, 8'(inj_cnt), 8'hFF);
      done("insertion");
      step(4);
      summarize();
   end
endmodule
`default_nettype wire
